/* src/rts_pkg.sv */
// Constants and carrier types for the alarm, countdown and supply register slice.
package rts_pkg;

  localparam logic [7:0] OFS_DAYDATE = 8'h15;
  localparam logic [7:0] OFS_COUNT = 8'h16;
  localparam logic [7:0] OFS_RELOAD = 8'h17;
  localparam logic [7:0] OFS_SUPPLY = 8'h18;

  localparam logic [7:0] RST_DAYDATE = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_RELOAD = 8'h00;
  localparam logic [1:0] RST_THRESH = 2'h3;
  localparam logic RST_BACKUP = 1'b0;
  localparam logic RST_OVERRIDE = 1'b0;

  localparam int DD_MASK_BIT = 7;
  localparam int DD_SEL_BIT = 6;
  localparam int DD_VAL_MSB = 5;
  localparam int THR_LSB = 4;
  localparam int BACKUP_BIT = 3;
  localparam int OVR_BIT = 2;

  // Bus address of the device; the value is arbitrary.
  localparam logic [6:0] DEV_ADDR = 7'h2a;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  typedef struct packed {
    logic [6:0] minute;
    logic [5:0] hour;
    logic [3:0] weekday;
    logic [5:0] monthday;
  } rts_time_t;

  typedef struct packed {
    logic [6:0] minute;
    logic [5:0] hour;
    logic minute_mask;
    logic hour_mask;
    logic irq_enable;
  } rts_alarm_cfg_t;

  typedef struct packed {
    logic comparators_on;
    logic threshold_active;
    logic [1:0] threshold_code;
    logic use_backup;
  } rts_supply_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_RXB = 5'b00010,
    S_ACK = 5'b00100,
    S_TXB = 5'b01000,
    S_MACK = 5'b10000
  } rts_state_t;

  typedef enum logic [2:0] {
    K_ADDR = 3'b001,
    K_PTR = 3'b010,
    K_DATA = 3'b100
  } rts_kind_t;

endpackage

/* src/rts_regs.sv */
// Serial register slice: alarm-2 day/date, countdown timer and supply selection.
`timescale 1ns/100ps
// Functional notes
// - Day/date bit 6: 0 matches date of month, 1 matches day of week.
// - Day/date bits 5:4 are tens, bits 3:0 units, both read/write.
// - Current count is an 8-bit read-only live value, reset zero.
// - Reading the current count returns its present value, no side effect.
// - Reload value is an 8-bit read/write register, reset zero.
// - In repeat mode the counter reloads from the reload value at zero.
// - Threshold code at bits 5:4: 1=1.8V, 2=2.0V, 3=2.4V, 0 reserved; resets 3.
// - Threshold applies only while manual override is 0.
// - Bit 3 picks backup (1) or main (0), only under manual override.
// - Override 0: comparators enabled, supply chosen automatically.
// - Override 1: comparators disabled, supply follows the backup choice bit.
// - With no masks set, alarm needs minute, hour and day/date equal.
// - All masks set fires every minute; only minute clear fires on minute match.
// - Alarm match drives the interrupt only when its enable is set.
module rts_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire rts_pkg::rts_time_t now,
  input wire logic minute_tick,
  input wire rts_pkg::rts_alarm_cfg_t alm_cfg,
  input wire logic timer_run,
  input wire logic timer_repeat,
  input wire logic timer_load,
  input wire logic timer_tick,
  input wire logic vcc_fail_in,
  output logic alarm2_match,
  output logic alarm2_irq,
  output logic [7:0] timer_count,
  output rts_pkg::rts_supply_t supply
);
  import rts_pkg::*;

  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic vcc_m, vcc_s;
  logic scl_rise, scl_fall, start, stop;

  rts_state_t state;
  rts_kind_t kind;
  logic [3:0] cnt;
  logic [7:0] shift, ptr, rd_data;
  logic rw, nack, sda_oe_reg, wr_stb;

  logic [7:0] daydate_reg, reload_reg, count_reg;
  logic [1:0] thresh_reg;
  logic backup_reg, override_reg, alarm2_match_reg, alarm2_irq_reg;
  rts_supply_t supply_reg;

  logic min_ok, hr_ok, dd_ok;
  logic [5:0] dd_target;

  // Bus lines and the comparator level come from outside the clock domain.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      vcc_m <= 1'b0;
      vcc_s <= 1'b0;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      vcc_m <= vcc_fail_in;
      vcc_s <= vcc_m;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start = scl_s & scl_d & sda_d & ~sda_s;
  assign stop = scl_s & scl_d & ~sda_d & sda_s;

  // A data byte is written at the pointer when its last bit has been taken.
  assign wr_stb = (state == S_RXB) && scl_fall && (cnt == BYTE_BITS) && (kind == K_DATA);

  always_comb begin
    unique case (ptr)
      OFS_DAYDATE: rd_data = daydate_reg;
      OFS_COUNT: rd_data = count_reg;
      OFS_RELOAD: rd_data = reload_reg;
      OFS_SUPPLY: rd_data = {2'b00, thresh_reg, backup_reg, override_reg, 2'b00};
      default: rd_data = 8'h00;
    endcase
  end

  // Serial engine: address byte, pointer byte, then data bytes with auto-increment.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      kind <= K_ADDR;
      cnt <= 4'h0;
      shift <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      nack <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start) begin
      state <= S_RXB;
      kind <= K_ADDR;
      cnt <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop) begin
      state <= S_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        S_RXB: begin
          if (scl_rise && cnt != BYTE_BITS) begin
            shift <= {shift[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end
          if (scl_fall && cnt == BYTE_BITS) begin
            state <= S_ACK;
            sda_oe_reg <= 1'b1;
            if (kind == K_ADDR) begin
              rw <= shift[0];
              if (shift[7:1] != DEV_ADDR) begin
                state <= S_IDLE;
                sda_oe_reg <= 1'b0;
              end
            end else if (kind == K_PTR) begin
              ptr <= shift;
            end else begin
              ptr <= ptr + 8'h01;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            cnt <= 4'h0;
            if (kind == K_ADDR && rw) begin
              state <= S_TXB;
              shift <= rd_data;
              sda_oe_reg <= ~rd_data[7];
            end else begin
              state <= S_RXB;
              sda_oe_reg <= 1'b0;
              kind <= (kind == K_ADDR) ? K_PTR : K_DATA;
            end
          end
        end
        S_TXB: begin
          if (scl_fall) begin
            cnt <= cnt + 4'h1;
            if (cnt == LAST_BIT) begin
              state <= S_MACK;
              sda_oe_reg <= 1'b0;
              ptr <= ptr + 8'h01;
            end else begin
              shift <= {shift[6:0], 1'b0};
              sda_oe_reg <= ~shift[6];
            end
          end
        end
        S_MACK: begin
          if (scl_rise) begin
            nack <= sda_s;
          end
          if (scl_fall) begin
            if (nack) begin
              state <= S_IDLE;
            end else begin
              state <= S_TXB;
              cnt <= 4'h0;
              shift <= rd_data;
              sda_oe_reg <= ~rd_data[7];
            end
          end
        end
        default: begin
          state <= S_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Host-writable storage; the current count ignores writes.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      daydate_reg <= RST_DAYDATE;
      reload_reg <= RST_RELOAD;
      thresh_reg <= RST_THRESH;
      backup_reg <= RST_BACKUP;
      override_reg <= RST_OVERRIDE;
    end else if (wr_stb) begin
      if (ptr == OFS_DAYDATE) begin
        daydate_reg <= shift;
      end
      if (ptr == OFS_RELOAD) begin
        reload_reg <= shift;
      end
      if (ptr == OFS_SUPPLY) begin
        thresh_reg <= shift[THR_LSB +: 2];
        backup_reg <= shift[BACKUP_BIT];
        override_reg <= shift[OVR_BIT];
      end
    end
  end

  // Countdown timer; a zero count reloads only in repeat mode, else it rests.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_reg <= RST_COUNT;
    end else if (timer_load) begin
      count_reg <= reload_reg;
    end else if (timer_run && timer_tick) begin
      if (count_reg != 8'h00) begin
        count_reg <= count_reg - 8'h01;
      end else if (timer_repeat) begin
        count_reg <= reload_reg;
      end
    end
  end

  // Alarm-2 comparison, evaluated on each new minute.
  assign dd_target = daydate_reg[DD_SEL_BIT] ? {2'b00, now.weekday} : now.monthday;
  assign min_ok = alm_cfg.minute_mask | (now.minute == alm_cfg.minute);
  assign hr_ok = alm_cfg.hour_mask | (now.hour == alm_cfg.hour);
  assign dd_ok = daydate_reg[DD_MASK_BIT] | (dd_target == daydate_reg[DD_VAL_MSB:0]);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alarm2_match_reg <= 1'b0;
      alarm2_irq_reg <= 1'b0;
    end else begin
      alarm2_match_reg <= minute_tick & min_ok & hr_ok & dd_ok;
      alarm2_irq_reg <= minute_tick & min_ok & hr_ok & dd_ok & alm_cfg.irq_enable;
    end
  end

  // Supply selection: automatic through the comparator, or host-forced.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      supply_reg <= '{~RST_OVERRIDE, ~RST_OVERRIDE, RST_THRESH, RST_BACKUP};
    end else begin
      supply_reg.comparators_on <= ~override_reg;
      supply_reg.threshold_active <= ~override_reg;
      supply_reg.threshold_code <= thresh_reg;
      supply_reg.use_backup <= override_reg ? backup_reg : vcc_s;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_reg;
  assign alarm2_match = alarm2_match_reg;
  assign alarm2_irq = alarm2_irq_reg;
  assign timer_count = count_reg;
  assign supply = supply_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_dd_select;
    minute_tick && !daydate_reg[DD_MASK_BIT] && daydate_reg[DD_SEL_BIT]
      && ({2'b00, now.weekday} != daydate_reg[DD_VAL_MSB:0]) |=> !alarm2_match;
  endproperty
  a_dd_select: assert property (p_dd_select) else $error("Weekday mismatch fired alarm.");

  property p_dd_write;
    wr_stb && ptr == OFS_DAYDATE |=> daydate_reg == $past(shift);
  endproperty
  a_dd_write: assert property (p_dd_write) else $error("Day/date write lost.");

  property p_count_ro;
    wr_stb && ptr == OFS_COUNT && !timer_load && !timer_tick |=> $stable(count_reg);
  endproperty
  a_count_ro: assert property (p_count_ro) else $error("Count changed by a write.");

  property p_read_live;
    state == S_ACK && scl_fall && kind == K_ADDR && rw && ptr == OFS_COUNT
      |=> shift == $past(count_reg);
  endproperty
  a_read_live: assert property (p_read_live) else $error("Read did not load live count.");

  property p_reload_write;
    wr_stb && ptr == OFS_RELOAD |=> reload_reg == $past(shift);
  endproperty
  a_reload_write: assert property (p_reload_write) else $error("Reload write lost.");

  property p_repeat;
    timer_run && timer_tick && timer_repeat && !timer_load && count_reg == 8'h00
      |=> count_reg == $past(reload_reg);
  endproperty
  a_repeat: assert property (p_repeat) else $error("Repeat reload missing.");

  property p_thresh;
    !override_reg |=> supply.threshold_active && supply.threshold_code == $past(thresh_reg);
  endproperty
  a_thresh: assert property (p_thresh) else $error("Threshold not applied.");

  property p_manual;
    override_reg |=> !supply.comparators_on && !supply.threshold_active
      && supply.use_backup == $past(backup_reg);
  endproperty
  a_manual: assert property (p_manual) else $error("Override not followed.");

  property p_auto;
    !override_reg |=> supply.comparators_on && supply.use_backup == $past(vcc_s);
  endproperty
  a_auto: assert property (p_auto) else $error("Automatic supply not followed.");

  property p_exact;
    minute_tick && !alm_cfg.minute_mask && now.minute != alm_cfg.minute |=> !alarm2_match;
  endproperty
  a_exact: assert property (p_exact) else $error("Alarm fired on minute mismatch.");

  property p_every_minute;
    minute_tick && alm_cfg.minute_mask && alm_cfg.hour_mask && daydate_reg[DD_MASK_BIT]
      |=> alarm2_match;
  endproperty
  a_every_minute: assert property (p_every_minute) else $error("Minute alarm missed.");

  property p_irq;
    alarm2_irq |-> alarm2_match && $past(alm_cfg.irq_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt without enable.");

endmodule

/* test/rtc_alarm_timer_supply_regs_tb.sv */
// Self-checking bench for the alarm, countdown and supply register slice.
`timescale 1ns/100ps
module rtc_alarm_timer_supply_regs_tb;
  import rts_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_low, sda_out, sda_oe, alarm2_match, alarm2_irq, nak;
  logic minute_tick, timer_run, timer_repeat, timer_load, timer_tick, vcc_fail_in;
  logic [7:0] timer_count, rd_data, r;
  logic [1:0] code;
  logic [31:0] rv;
  rts_time_t now;
  rts_alarm_cfg_t alm_cfg;
  rts_supply_t supply;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  wire logic sda = !sda_low && (sda_oe ? sda_out : 1'b1);
  always #5 sys_clk = ~sys_clk;
  rts_host i_host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  rts_regs i_dut (.sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .now(now), .minute_tick(minute_tick),
    .alm_cfg(alm_cfg), .timer_run(timer_run), .timer_repeat(timer_repeat),
    .timer_load(timer_load), .timer_tick(timer_tick), .vcc_fail_in(vcc_fail_in),
    .alarm2_match(alarm2_match), .alarm2_irq(alarm2_irq), .timer_count(timer_count),
    .supply(supply));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    i_host.wr(a, d, nak);
    chk("write ack", 8'h00, {7'h0, nak});
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp, input string what);
    i_host.rd(a, rd_data, nak);
    chk("read ack", 8'h00, {7'h0, nak});
    chk(what, exp, rd_data);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      timer_tick <= 1'b1;
      @(posedge sys_clk);
      timer_tick <= 1'b0;
    end
    #1;
  endtask
  function automatic logic exp_alarm(logic [7:0] dd, rts_alarm_cfg_t c, rts_time_t t);
    logic [5:0] day;
    day = dd[DD_SEL_BIT] ? {2'b00, t.weekday} : t.monthday;
    return (c.minute_mask || c.minute == t.minute) && (c.hour_mask || c.hour == t.hour)
      && (dd[DD_MASK_BIT] || dd[5:0] == day);
  endfunction
  // Mask patterns: 0 all set, 1 minute clear, 2 hour too, 3 none set.
  task automatic alarm_case(input int k);
    rts_time_t t;
    rts_alarm_cfg_t c;
    logic [7:0] dd;
    logic e;
    rv = $urandom;
    t = rv[22:0];
    rv = $urandom;
    c.minute = rv[0] ? t.minute : rv[7:1];
    c.hour = rv[8] ? t.hour : rv[14:9];
    c.minute_mask = (k == 0);
    c.hour_mask = (k <= 1);
    c.irq_enable = rv[15];
    dd = {k <= 2, rv[16], rv[17] ? (rv[16] ? {2'b00, t.weekday} : t.monthday) : rv[23:18]};
    wreg(OFS_DAYDATE, dd);
    rreg(OFS_DAYDATE, dd, "daydate");
    e = exp_alarm(dd, c, t);
    @(posedge sys_clk);
    now <= t;
    alm_cfg <= c;
    @(posedge sys_clk);
    minute_tick <= 1'b1;
    @(posedge sys_clk);
    minute_tick <= 1'b0;
    #1;
    chk("alarm match", {7'h0, e}, {7'h0, alarm2_match});
    chk("alarm irq", {7'h0, e & c.irq_enable}, {7'h0, alarm2_irq});
  endtask
  initial begin
    {minute_tick, timer_run, timer_repeat, timer_load, timer_tick, vcc_fail_in} = '0;
    now = '0;
    alm_cfg = '0;
    rv = $urandom(5456);
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("supply rst", 8'h1e, {3'h0, supply});
    rreg(OFS_DAYDATE, 8'h00, "daydate rst");
    rreg(OFS_COUNT, 8'h00, "count rst");
    rreg(OFS_RELOAD, 8'h00, "reload rst");
    rreg(OFS_SUPPLY, 8'h30, "supply rst");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      rv = $urandom;
      code = rv[1:0];
      if (code == 2'h0) code = 2'h3;
      @(posedge sys_clk);
      vcc_fail_in <= rv[2];
      wreg(OFS_SUPPLY, {rv[7:6], code, rv[3], rv[4], rv[9:8]});
      repeat (5) @(posedge sys_clk);
      #1;
      chk("comparators", {7'h0, !rv[4]}, {7'h0, supply.comparators_on});
      chk("thr active", {7'h0, !rv[4]}, {7'h0, supply.threshold_active});
      chk("thr code", {6'h0, code}, {6'h0, supply.threshold_code});
      chk("backup", {7'h0, rv[4] ? rv[3] : rv[2]}, {7'h0, supply.use_backup});
      rreg(OFS_SUPPLY, {2'b00, code, rv[3], rv[4], 2'b00}, "supply cfg");
    end
    $display("test supply done");
    for (int i = 0; i < 12; i++) alarm_case(i % 4);
    $display("test alarm done");
    rv = $urandom;
    r = {3'h0, rv[4:0]} | 8'h02;
    wreg(OFS_RELOAD, r);
    rreg(OFS_RELOAD, r, "reload");
    wreg(OFS_COUNT, 8'h5a);
    rreg(OFS_COUNT, 8'h00, "count ro");
    @(posedge sys_clk);
    timer_load <= 1'b1;
    timer_run <= 1'b1;
    timer_repeat <= 1'b1;
    @(posedge sys_clk);
    timer_load <= 1'b0;
    rreg(OFS_COUNT, r, "count live");
    rreg(OFS_COUNT, r, "count again");
    tick(r);
    chk("count zero", 8'h00, timer_count);
    tick(1);
    chk("count reload", r, timer_count);
    rreg(OFS_COUNT, r, "count read");
    timer_repeat <= 1'b0;
    tick(r + 1);
    chk("count hold", 8'h00, timer_count);
    $display("test timer done");
    give_verdict();
  end
endmodule

/* test/rts_host.sv */
// Serial bus host model that reads and writes the register slice.
`timescale 1ns/100ps
module rts_host (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  import rts_pkg::*;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic half();
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic put(input logic b);
    sda_low <= !b;
    half();
    scl <= 1'b1;
    half();
    scl <= 1'b0;
  endtask
  // The line is released, so the pull-up shows whenever the device is silent.
  task automatic get(output logic b);
    sda_low <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    b = sda;
    scl <= 1'b0;
  endtask
  task automatic start();
    sda_low <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    scl <= 1'b0;
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask
  task automatic send(input logic [7:0] d, output logic nak);
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(nak);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nak);
    logic n0, n1, n2;
    start();
    send({DEV_ADDR, 1'b0}, n0);
    send(a, n1);
    send(d, n2);
    stop();
    nak = n0 | n1 | n2;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic nak);
    logic n0, n1, n2;
    start();
    send({DEV_ADDR, 1'b0}, n0);
    send(a, n1);
    start();
    send({DEV_ADDR, 1'b1}, n2);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
    stop();
    nak = n0 | n1 | n2;
  endtask
endmodule
